//--- design/descriptor_dma_cmd_exec.sv
`timescale 1ns/1ps
// Summary of operation
// - stream commands: word 2 is memory buffer
// - immediate commands: key selects address space
// - keyed input/output uses second_address_pointer
// - key 0-3 stream, 5 regs, 6 system, 7 device
// - interrupt condition: masked status equals masked value
// - irq field: never, set, cleared, always
// - simpler interrupt condition is allowed
// - no interrupt pin: ignore irq field
// - branch condition: masked status equals masked value
// - branch field: never, set, cleared, always
// - pointer takes next descriptor or branch target
// - word 1 is branch target or immediate
// - wait condition: masked status equals masked value
// - wait field: never, set, cleared, always
// - wait precedes status, branch, interrupt, fetch
// - byte count from word 3 bits 15-0
// - status into word 0, active forced one
// - flush writes partial status with flush set
// - device may raise flush itself
// - residual count into word 0 bits 15-0
// - status and residual in one write
module descriptor_dma_cmd_exec (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic mem_req_o,
  output dma_cmd_pkg::mem_cmd_t mem_cmd_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic xfer_start_o,
  output dma_cmd_pkg::xfer_cmd_t xfer_cmd_o,
  input wire logic xfer_done_i,
  input wire logic [15:0] xfer_residual_i,
  input wire logic [15:0] xfer_remaining_i,
  input wire logic dev_flush_req_i,
  output logic irq_o
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_XFER, ST_FLUSHWR, ST_IMM, ST_PAUSE, ST_STATWR, ST_NEXT
  } exec_state_t;

  exec_state_t state_reg;
  logic [31:0] cmd_ptr_reg;
  logic [31:0] addr2_reg;
  logic [15:0] ctl_reg;
  logic [15:0] ctl_next;
  logic active_reg;
  logic [15:0] irq_sel_reg;
  logic [15:0] jmp_sel_reg;
  logic [15:0] pause_sel_reg;
  logic [31:0] w3_reg;
  logic [31:0] w2_reg;
  logic [31:0] w1_reg;
  logic [1:0] idx_reg;
  logic [1:0] idx_dec;
  logic [15:0] residual_reg;
  logic done_pend_reg;
  logic [15:0] done_res_reg;
  logic apb_wr;
  logic [3:0] cmd_f;
  logic [2:0] key_f;
  logic [2:0] imm_bytes;
  logic irq_cond;
  logic jmp_cond;
  logic pause_cond;
  logic pause_now;
  logic take_jump;

  // masked equality of the general_status_bits against a select word
  function automatic logic sel_match(input logic [15:0] sel, input logic [7:0] sbits);
    sel_match = (sbits & sel[15:8]) == (sel[7:0] & sel[15:8]);
  endfunction : sel_match

  // shared action decode for the irq, jump and pause fields
  function automatic logic act_decide(input logic [1:0] code, input logic cond);
    case (code)
      dma_cmd_pkg::ACT_SET: act_decide = cond;
      dma_cmd_pkg::ACT_CLR: act_decide = !cond;
      dma_cmd_pkg::ACT_ALWAYS: act_decide = 1'b1;
      default: act_decide = 1'b0;
    endcase
  endfunction : act_decide

  // key to address space
  function automatic logic [1:0] key_space(input logic [2:0] key);
    case (key)
      dma_cmd_pkg::KEY_REGS: key_space = dma_cmd_pkg::SPC_REGS;
      dma_cmd_pkg::KEY_SYSTEM: key_space = dma_cmd_pkg::SPC_SYS;
      dma_cmd_pkg::KEY_DEVICE: key_space = dma_cmd_pkg::SPC_DEV;
      default: key_space = dma_cmd_pkg::SPC_STREAM;
    endcase
  endfunction : key_space

  // descriptor field views
  assign cmd_f = w3_reg[dma_cmd_pkg::CMD_HI:dma_cmd_pkg::CMD_LO];
  assign key_f = w3_reg[dma_cmd_pkg::KEY_HI:dma_cmd_pkg::KEY_LO];
  assign idx_dec = idx_reg - 2'h1;
  // immediate size: 0b00x -> 1, 0b01x -> 2, 0b1xx -> 4
  assign imm_bytes = w3_reg[2] ? 3'h4 : (w3_reg[1] ? 3'h2 : 3'h1);

  // full masked compare kept; cheaper forms are allowed but unused
  assign irq_cond = sel_match(irq_sel_reg, ctl_reg[7:0]);
  assign jmp_cond = sel_match(jmp_sel_reg, ctl_reg[7:0]);
  assign pause_cond = sel_match(pause_sel_reg, ctl_reg[7:0]);
  assign pause_now = act_decide(w3_reg[dma_cmd_pkg::PAUSE_HI:dma_cmd_pkg::PAUSE_LO],
    pause_cond);
  // immediates carry a reserved zero branch field, so only transfers and nop jump
  assign take_jump = (cmd_f <= dma_cmd_pkg::CMD_IN_LAST || cmd_f == dma_cmd_pkg::CMD_NOP)
    && act_decide(w3_reg[dma_cmd_pkg::JMP_HI:dma_cmd_pkg::JMP_LO], jmp_cond);

  assign apb_wr = psel_i && penable_i && pwrite_i && pready_o;
  // control write: upper half is a bit mask for the lower half
  assign ctl_next = (ctl_reg & ~pwdata_i[31:16]) | (pwdata_i[15:0] & pwdata_i[31:16]);

  // apb slave: answer one cycle after setup, read data sampled in setup, write data in access
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      if (psel_i && !penable_i)
      begin
        case (paddr_i)
          dma_cmd_pkg::OFF_CMD_PTR: prdata_o <= cmd_ptr_reg;
          dma_cmd_pkg::OFF_CTL: prdata_o <= {16'h0000, ctl_reg};
          dma_cmd_pkg::OFF_STATE: prdata_o <= {16'h0000,
            ctl_reg | (active_reg ? dma_cmd_pkg::ACTIVE_MASK : 16'h0000)};
          dma_cmd_pkg::OFF_IRQ_SEL: prdata_o <= {8'h00, irq_sel_reg[15:8], 8'h00, irq_sel_reg[7:0]};
          dma_cmd_pkg::OFF_JMP_SEL: prdata_o <= {8'h00, jmp_sel_reg[15:8], 8'h00, jmp_sel_reg[7:0]};
          dma_cmd_pkg::OFF_PAUSE_SEL:
            prdata_o <= {8'h00, pause_sel_reg[15:8], 8'h00, pause_sel_reg[7:0]};
          dma_cmd_pkg::OFF_ADDR2: prdata_o <= addr2_reg;
          default:
          begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b1; // unmapped address
          end
        endcase
      end
    end
  end

  // select registers and second address pointer
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_sel_reg <= 16'h0000;
      jmp_sel_reg <= 16'h0000;
      pause_sel_reg <= 16'h0000;
      addr2_reg <= 32'h0000_0000;
    end
    else if (apb_wr)
    begin
      case (paddr_i)
        dma_cmd_pkg::OFF_IRQ_SEL: irq_sel_reg <= {pwdata_i[23:16], pwdata_i[7:0]};
        dma_cmd_pkg::OFF_JMP_SEL: jmp_sel_reg <= {pwdata_i[23:16], pwdata_i[7:0]};
        dma_cmd_pkg::OFF_PAUSE_SEL: pause_sel_reg <= {pwdata_i[23:16], pwdata_i[7:0]};
        dma_cmd_pkg::OFF_ADDR2: addr2_reg <= pwdata_i;
        default: ;
      endcase
    end
  end

  // channel_control_word: software write, hardware flush clear, device flush set last
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ctl_reg <= dma_cmd_pkg::CTL_RESET;
    else
    begin
      if (apb_wr && paddr_i == dma_cmd_pkg::OFF_CTL)
        ctl_reg <= ctl_next;
      if (state_reg == ST_FLUSHWR && mem_ack_i)
        ctl_reg[dma_cmd_pkg::BIT_FLUSH] <= 1'b0;
      if (dev_flush_req_i)
        ctl_reg[dma_cmd_pkg::BIT_FLUSH] <= 1'b1;
    end
  end

  // active: cleared by stop, set by any control write that leaves run high
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      active_reg <= 1'b0;
    else
    begin
      if (state_reg == ST_DECODE && cmd_f > dma_cmd_pkg::CMD_NOP)
        active_reg <= 1'b0;
      if (apb_wr && paddr_i == dma_cmd_pkg::OFF_CTL && ctl_next[dma_cmd_pkg::BIT_RUN])
        active_reg <= 1'b1;
    end
  end

  // done can arrive while a flush report is in flight, so it is held here
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      done_pend_reg <= 1'b0;
      done_res_reg <= 16'h0000;
    end
    else
    begin
      if (state_reg == ST_XFER && !ctl_reg[dma_cmd_pkg::BIT_FLUSH])
        done_pend_reg <= 1'b0;
      if (xfer_done_i)
      begin
        done_pend_reg <= 1'b1;
        done_res_reg <= xfer_residual_i;
      end
    end
  end

  // command sequencer with its memory and transfer ports
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= ST_IDLE;
      cmd_ptr_reg <= 32'h0000_0000;
      w3_reg <= 32'h0000_0000;
      w2_reg <= 32'h0000_0000;
      w1_reg <= 32'h0000_0000;
      idx_reg <= 2'h0;
      residual_reg <= 16'h0000;
      mem_req_o <= 1'b0;
      mem_cmd_o <= '0;
      xfer_start_o <= 1'b0;
      xfer_cmd_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      xfer_start_o <= 1'b0;
      irq_o <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          // pointer only loads while the channel is idle
          if (apb_wr && paddr_i == dma_cmd_pkg::OFF_CMD_PTR)
            cmd_ptr_reg <= pwdata_i;
          else if (ctl_reg[dma_cmd_pkg::BIT_RUN] && active_reg)
          begin
            state_reg <= ST_FETCH;
            idx_reg <= 2'h3;
            mem_req_o <= 1'b1;
            mem_cmd_o <= '{we: 1'b0, space: dma_cmd_pkg::SPC_SYS, nbytes: 3'h4,
              addr: cmd_ptr_reg + dma_cmd_pkg::WORD3_OFS, wdata: 32'h0000_0000};
          end
        end
        ST_FETCH:
        begin
          // words 3, 2, 1 fetched high to low; word 0 is only written
          if (mem_ack_i)
          begin
            case (idx_reg)
              2'h3: w3_reg <= mem_rdata_i;
              2'h2: w2_reg <= mem_rdata_i;
              default: w1_reg <= mem_rdata_i;
            endcase
            if (idx_reg == 2'h1)
            begin
              mem_req_o <= 1'b0;
              state_reg <= ST_DECODE;
            end
            else
            begin
              idx_reg <= idx_dec;
              mem_cmd_o.addr <= cmd_ptr_reg + {28'h0000000, idx_dec, 2'b00};
            end
          end
        end
        ST_DECODE:
        begin
          residual_reg <= 16'h0000;
          case (cmd_f)
            dma_cmd_pkg::CMD_OUT_MORE, dma_cmd_pkg::CMD_OUT_LAST,
            dma_cmd_pkg::CMD_IN_MORE, dma_cmd_pkg::CMD_IN_LAST:
            begin
              xfer_start_o <= 1'b1;
              xfer_cmd_o.to_mem <= cmd_f[1];
              xfer_cmd_o.key <= key_f;
              xfer_cmd_o.space <= key_space(key_f);
              xfer_cmd_o.mem_addr <= w2_reg;
              xfer_cmd_o.addr2 <= addr2_reg;
              xfer_cmd_o.count <= w3_reg[dma_cmd_pkg::CNT_HI:0];
              state_reg <= ST_XFER;
            end
            dma_cmd_pkg::CMD_STORE, dma_cmd_pkg::CMD_LOAD:
            begin
              // stream keys here are a software error; result left undefined
              mem_req_o <= 1'b1;
              mem_cmd_o.we <= (cmd_f == dma_cmd_pkg::CMD_STORE);
              mem_cmd_o.space <= key_space(key_f);
              mem_cmd_o.nbytes <= imm_bytes;
              mem_cmd_o.addr <= {w2_reg[31:2], w2_reg[1] & ~imm_bytes[2],
                w2_reg[0] & imm_bytes[0]};
              mem_cmd_o.wdata <= w1_reg;
              state_reg <= ST_IMM;
            end
            dma_cmd_pkg::CMD_NOP: state_reg <= ST_PAUSE;
            default: state_reg <= ST_IDLE; // stop and reserved codes
          endcase
        end
        ST_XFER:
        begin
          if (ctl_reg[dma_cmd_pkg::BIT_FLUSH])
          begin
            // partial report: status with flush set and bytes still to go
            mem_req_o <= 1'b1;
            mem_cmd_o <= '{we: 1'b1, space: dma_cmd_pkg::SPC_SYS, nbytes: 3'h4,
              addr: cmd_ptr_reg, wdata: {ctl_reg | dma_cmd_pkg::ACTIVE_MASK,
              xfer_remaining_i}};
            state_reg <= ST_FLUSHWR;
          end
          else if (done_pend_reg)
          begin
            residual_reg <= done_res_reg;
            state_reg <= ST_PAUSE;
          end
        end
        ST_FLUSHWR:
        begin
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            state_reg <= ST_XFER;
          end
        end
        ST_IMM:
        begin
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            if (!mem_cmd_o.we)
              w1_reg <= mem_rdata_i;
            state_reg <= ST_PAUSE;
          end
        end
        ST_PAUSE:
        begin
          // condition sampled every cycle; completion waits here
          if (!pause_now)
          begin
            mem_req_o <= 1'b1;
            mem_cmd_o <= '{we: 1'b1, space: dma_cmd_pkg::SPC_SYS, nbytes: 3'h4,
              addr: cmd_ptr_reg, wdata: {ctl_reg | dma_cmd_pkg::ACTIVE_MASK,
              residual_reg}};
            state_reg <= ST_STATWR;
          end
        end
        ST_STATWR:
        begin
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            irq_o <= dma_cmd_pkg::HAS_IRQ_PIN && act_decide(
              w3_reg[dma_cmd_pkg::IRQ_HI:dma_cmd_pkg::IRQ_LO], irq_cond);
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          cmd_ptr_reg <= take_jump ? w1_reg : cmd_ptr_reg + dma_cmd_pkg::DESC_STRIDE;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_stream_buf;
    xfer_start_o |-> xfer_cmd_o.mem_addr == w2_reg && xfer_cmd_o.addr2 == addr2_reg;
  endproperty
  a_stream_buf: assert property (p_stream_buf) else $error("transfer addresses wrong");

  property p_imm_space;
    state_reg == ST_IMM && mem_req_o && key_f == dma_cmd_pkg::KEY_DEVICE
      |-> mem_cmd_o.space == dma_cmd_pkg::SPC_DEV;
  endproperty
  a_imm_space: assert property (p_imm_space) else $error("device key not device space");

  property p_irq_cause;
    irq_o |-> $past(state_reg) == ST_STATWR
      && w3_reg[dma_cmd_pkg::IRQ_HI:dma_cmd_pkg::IRQ_LO] != dma_cmd_pkg::ACT_NEVER;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

  property p_jump;
    state_reg == ST_NEXT && take_jump |=> cmd_ptr_reg == $past(w1_reg);
  endproperty
  a_jump: assert property (p_jump) else $error("branch target not loaded");

  property p_seq;
    state_reg == ST_NEXT && !take_jump |=> cmd_ptr_reg == $past(cmd_ptr_reg) + 32'h10;
  endproperty
  a_seq: assert property (p_seq) else $error("next descriptor address wrong");

  property p_hold;
    state_reg == ST_PAUSE && pause_now |=> state_reg == ST_PAUSE && !mem_req_o && !irq_o;
  endproperty
  a_hold: assert property (p_hold) else $error("completion ran during wait");

  property p_resume;
    state_reg == ST_PAUSE && !pause_now |=> state_reg == ST_STATWR && mem_req_o;
  endproperty
  a_resume: assert property (p_resume) else $error("wait not released");

  property p_count;
    xfer_start_o |-> xfer_cmd_o.count == w3_reg[15:0];
  endproperty
  a_count: assert property (p_count) else $error("byte count mismatch");

  property p_status_word;
    state_reg == ST_STATWR && mem_req_o |-> mem_cmd_o.we && mem_cmd_o.addr == cmd_ptr_reg
      && mem_cmd_o.wdata[16 + dma_cmd_pkg::BIT_ACTIVE] && mem_cmd_o.nbytes == 3'h4;
  endproperty
  a_status_word: assert property (p_status_word) else $error("bad status write");

  property p_flush_word;
    state_reg == ST_FLUSHWR && mem_req_o |-> mem_cmd_o.wdata[16 + dma_cmd_pkg::BIT_FLUSH];
  endproperty
  a_flush_word: assert property (p_flush_word) else $error("flush bit missing");
endmodule : descriptor_dma_cmd_exec

//--- design/dma_cmd_pkg.sv
package dma_cmd_pkg;
  // register byte offsets on the apb port
  localparam logic [7:0] OFF_CMD_PTR = 8'h00;
  localparam logic [7:0] OFF_CTL = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;
  localparam logic [7:0] OFF_IRQ_SEL = 8'h0c;
  localparam logic [7:0] OFF_JMP_SEL = 8'h10;
  localparam logic [7:0] OFF_PAUSE_SEL = 8'h14;
  localparam logic [7:0] OFF_ADDR2 = 8'h18;
  // channel_state_word bit positions
  localparam int BIT_RUN = 15;
  localparam int BIT_FLUSH = 13;
  localparam int BIT_ACTIVE = 10;
  localparam logic [15:0] ACTIVE_MASK = 16'h0400;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // descriptor word 3 fields
  localparam int CMD_HI = 31;
  localparam int CMD_LO = 28;
  localparam int KEY_HI = 26;
  localparam int KEY_LO = 24;
  localparam int IRQ_HI = 21;
  localparam int IRQ_LO = 20;
  localparam int JMP_HI = 19;
  localparam int JMP_LO = 18;
  localparam int PAUSE_HI = 17;
  localparam int PAUSE_LO = 16;
  localparam int CNT_HI = 15;
  // condition select layout: mask in 23:16, value in 7:0
  localparam int SEL_MASK_LO = 16;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [31:0] WORD3_OFS = 32'h0000_000c;
  // command codes
  localparam logic [3:0] CMD_OUT_MORE = 4'h0;
  localparam logic [3:0] CMD_OUT_LAST = 4'h1;
  localparam logic [3:0] CMD_IN_MORE = 4'h2;
  localparam logic [3:0] CMD_IN_LAST = 4'h3;
  localparam logic [3:0] CMD_STORE = 4'h4;
  localparam logic [3:0] CMD_LOAD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h6;
  // key codes above the four stream_port_keys
  localparam logic [2:0] KEY_REGS = 3'h5;
  localparam logic [2:0] KEY_SYSTEM = 3'h6;
  localparam logic [2:0] KEY_DEVICE = 3'h7;
  // address spaces on the memory port
  localparam logic [1:0] SPC_SYS = 2'h0;
  localparam logic [1:0] SPC_DEV = 2'h1;
  localparam logic [1:0] SPC_REGS = 2'h2;
  localparam logic [1:0] SPC_STREAM = 2'h3;
  // action field codes
  localparam logic [1:0] ACT_NEVER = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_ALWAYS = 2'h3;
  // zero means no interrupt pin: the irq field is ignored
  localparam logic HAS_IRQ_PIN = 1'b1;

  typedef struct packed {
    logic we;
    logic [1:0] space;
    logic [2:0] nbytes;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;

  typedef struct packed {
    logic to_mem;
    logic [2:0] key;
    logic [1:0] space;
    logic [31:0] mem_addr;
    logic [31:0] addr2;
    logic [15:0] count;
  } xfer_cmd_t;
endpackage : dma_cmd_pkg

//--- dv/descriptor_dma_cmd_exec_bench.sv
`timescale 1ns/1ps
module descriptor_dma_cmd_exec_bench;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, mreq, mack, xst, xdone, irq, err;
  logic flush, fl_en;
  logic [7:0] s;
  logic [15:0] xrem_d;
  int n_part;
  logic [7:0] paddr;
  logic [31:0] pwd, prd, mrd, rd;
  logic [15:0] resid, xrem;
  dma_cmd_pkg::mem_cmd_t mcmd;
  dma_cmd_pkg::xfer_cmd_t xcmd, exp_x;
  int n_fail, n_compared, cyc, n_irq, it, sd;
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  descriptor_dma_cmd_exec dut_u (.ref_clk_i(clk), .resetn_i(rstn), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(pready), .pslverr_o(pslverr), .mem_req_o(mreq), .mem_cmd_o(mcmd),
    .mem_ack_i(mack), .mem_rdata_i(mrd), .xfer_start_o(xst), .xfer_cmd_o(xcmd),
    .xfer_done_i(xdone), .xfer_residual_i(resid), .xfer_remaining_i(xrem),
    .dev_flush_req_i(flush), .irq_o(irq));
  dma_far_side part_u (.clk_i(clk), .resetn_i(rstn), .mem_req_i(mreq), .mem_cmd_i(mcmd),
    .mem_ack_o(mack), .mem_rdata_o(mrd), .xfer_start_i(xst), .resid_i(resid),
    .xfer_done_o(xdone), .xfer_remaining_o(xrem));
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  // one apb transfer, entered right after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prd;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  function logic cond(input logic [31:0] sel, input logic [7:0] s);
    return (s & sel[23:16]) == (sel[7:0] & sel[23:16]);
  endfunction : cond
  function logic act(input logic [1:0] a, input logic c);
    return a == dma_cmd_pkg::ACT_ALWAYS || (a == dma_cmd_pkg::ACT_SET && c)
      || (a == dma_cmd_pkg::ACT_CLR && !c);
  endfunction : act
  task wait_status(input int lim);
    // a partial report carries the flush bit, so only the final word ends the wait
    for (int k = 0; k < lim && (part_u.mem[0][26] !== 1'b1 || part_u.mem[0][29] !== 1'b0); k++)
      @(posedge clk);
  endtask : wait_status
  // one random descriptor followed by a stop
  task run_one;
    logic [3:0] cmd;
    logic [2:0] key;
    logic [1:0] ia, ja, wa, sp;
    logic [31:0] isel, jsel, wsel, a2, w1, w2;
    logic [15:0] cnt;
    logic xf, br;
    int k;
    k = $urandom_range(5);
    cmd = (k == 5) ? dma_cmd_pkg::CMD_NOP : 4'(k);
    xf = cmd < 4'h4;
    key = xf ? 3'($urandom_range(7)) : 3'($urandom_range(7, 5));
    if (key == 3'h4 || cmd == dma_cmd_pkg::CMD_NOP)
      key = 3'h0;
    sp = key < 3'h4 ? dma_cmd_pkg::SPC_STREAM : key == 3'h5 ? dma_cmd_pkg::SPC_REGS
      : key == 3'h6 ? dma_cmd_pkg::SPC_SYS : dma_cmd_pkg::SPC_DEV;
    ia = 2'($urandom_range(3));
    ja = xf || cmd == dma_cmd_pkg::CMD_NOP ? 2'($urandom_range(3)) : 2'h0;
    wa = 2'($urandom_range(2));
    isel = $urandom;
    jsel = $urandom;
    wsel = $urandom | 32'h0001_0000;
    a2 = $urandom;
    s = 8'($urandom);
    // device flush only on transfers that do not pause, so the pause check stays clean
    fl_en = xf && !act(wa, cond(wsel, s)) && ($urandom_range(1) == 1);
    cnt = xf ? 16'($urandom_range(65535, 1)) : 16'h0004;
    resid <= xf ? 16'($urandom_range(cnt)) : 16'h0000;
    w1 = cmd == dma_cmd_pkg::CMD_STORE ? $urandom : 32'h0000_0080;
    w2 = cmd == dma_cmd_pkg::CMD_STORE ? 32'h0000_00c0 : $urandom;
    part_u.mem[0] = 32'h0;
    part_u.mem[1] = w1;
    part_u.mem[2] = w2;
    part_u.mem[3] = {cmd, 1'b0, key, 2'b00, ia, ja, wa, cnt};
    part_u.mem[7] = 32'h7000_0000;
    part_u.mem[35] = 32'h7000_0000;
    part_u.mem[48] = 32'h0;
    exp_x = '{cmd[1], key, sp, w2, a2, cnt};
    apb(1'b1, dma_cmd_pkg::OFF_IRQ_SEL, isel);
    apb(1'b1, dma_cmd_pkg::OFF_JMP_SEL, jsel);
    apb(1'b1, dma_cmd_pkg::OFF_PAUSE_SEL, wsel);
    apb(1'b1, dma_cmd_pkg::OFF_ADDR2, a2);
    apb(1'b1, dma_cmd_pkg::OFF_CMD_PTR, 32'h0);
    n_irq = 0;
    n_part = 0;
    apb(1'b1, dma_cmd_pkg::OFF_CTL, {16'h80ff, 8'h80, s});
    if (act(wa, cond(wsel, s)))
    begin
      wait_status(150);
      check(part_u.mem[0] === 32'h0 && n_irq == 0, "no status while paused");
      s = wa == dma_cmd_pkg::ACT_SET ? s ^ wsel[23:16]
        : (s & ~wsel[23:16]) | (wsel[7:0] & wsel[23:16]);
      apb(1'b1, dma_cmd_pkg::OFF_CTL, {16'h00ff, 8'h00, s});
    end
    wait_status(400);
    repeat (30) @(posedge clk);
    check(part_u.mem[0] === {8'h84, s, xf ? resid : 16'h0}, "status word");
    br = act(ja, cond(jsel, s));
    apb(1'b0, dma_cmd_pkg::OFF_CMD_PTR, 32'h0);
    check(rd === (br ? 32'h80 : 32'h10), "next pointer");
    check(n_irq == (act(ia, cond(isel, s)) ? 1 : 0), "interrupt count");
    check(n_part == (fl_en ? 1 : 0), "partial report count");
    if (cmd == dma_cmd_pkg::CMD_STORE)
      check(part_u.mem[48] === w1, "immediate store");
    apb(1'b1, dma_cmd_pkg::OFF_CTL, 32'h8000_0000);
  endtask : run_one
  // interrupts, transfer starts and the run ceiling
  always @(posedge clk)
  begin
    cyc++;
    if (irq === 1'b1)
      n_irq++;
    // one-cycle device flush request in the cycle after a transfer starts
    flush <= xst === 1'b1 && fl_en;
    // remaining count as the design saw it, frozen while the partial write stands
    if (!(mreq === 1'b1 && mcmd.we === 1'b1 && mcmd.addr === 32'h0 && mcmd.wdata[29] === 1'b1))
      xrem_d <= xrem;
    if (mack === 1'b1 && mcmd.we === 1'b1 && mcmd.addr === 32'h0 && mcmd.wdata[29] === 1'b1)
    begin
      n_part++;
      check(mcmd.wdata === {8'ha4, s, xrem_d}, "partial status word");
    end
    if (xst === 1'b1)
      check(xcmd === exp_x, "transfer command");
    if (cyc > 60000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  // reset, register corners, then random descriptors
  initial
  begin
    {rstn, psel, pen, pwr, paddr, pwd, resid} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    sd = $urandom(32'hfd4d);
    apb(1'b1, 8'h40, 32'h1);
    check(err === 1'b1, "unmapped write");
    apb(1'b0, 8'h40, 32'h0);
    check(err === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, dma_cmd_pkg::OFF_STATE, 32'hffff_ffff);
    apb(1'b0, dma_cmd_pkg::OFF_STATE, 32'h0);
    check(err === 1'b0 && rd === 32'h0, "state is read-only");
    for (it = 0; it < 40; it++)
      run_one();
    give_verdict();
  end
endmodule : descriptor_dma_cmd_exec_bench

//--- dv/dma_far_side.sv
`timescale 1ns/1ps
// memory and stream device seen from the far side of the channel
module dma_far_side (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic mem_req_i,
  input dma_cmd_pkg::mem_cmd_t mem_cmd_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o,
  input wire logic xfer_start_i,
  input wire logic [15:0] resid_i,
  output logic xfer_done_o,
  output logic [15:0] xfer_remaining_o
);
  logic [31:0] mem [64];
  logic [2:0] wait_cnt;
  logic [4:0] busy_cnt;
  // answers after 0..3 stall cycles; read data scrambles when not valid
  always @(posedge clk_i)
  begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (!resetn_i)
    begin
      mem_rdata_o <= 32'h0000_0000;
      wait_cnt <= 3'h0;
    end
    else if (mem_req_i && !mem_ack_o)
    begin
      if (wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
      else
      begin
        mem_ack_o <= 1'b1;
        wait_cnt <= 3'($urandom_range(3));
        mem_rdata_o <= mem[mem_cmd_i.addr[7:2]];
        if (mem_cmd_i.we)
          mem[mem_cmd_i.addr[7:2]] <= mem_cmd_i.wdata;
      end
    end
  end
  // transfer ends after a random stall with the residual the bench chose
  always @(posedge clk_i)
  begin
    xfer_done_o <= 1'b0;
    if (!resetn_i)
    begin
      busy_cnt <= 5'h00;
      xfer_remaining_o <= 16'h0000;
    end
    else if (xfer_start_i)
    begin
      busy_cnt <= 5'($urandom_range(20, 4));
      xfer_remaining_o <= 16'hffff;
    end
    else if (busy_cnt == 5'h01)
    begin
      xfer_done_o <= 1'b1;
      busy_cnt <= 5'h00;
    end
    else if (busy_cnt != 5'h00)
    begin
      busy_cnt <= busy_cnt - 5'h01;
      xfer_remaining_o <= xfer_remaining_o - 16'h0001;
    end
  end
endmodule : dma_far_side
